// ==== rtl/pwm_channel.sv ====
// Double buffered PWM channel with its own timer base
// Functional notes
// - Duty writes anytime, applied at period match
// - All values zero keeps pin low
// - Secondary above period keeps pin high
// - Period is (period+1) ticks times prescale
// - Timer counts at oscillator over two, divided by prescale
// - Sixteen-bit period gives sixteen-bit resolution
module pwm_channel (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // Configuration
  input wire logic I_ENABLE,
  input wire logic [1:0] I_PRESCALE,
  input wire logic [15:0] I_PERIOD,
  // Duty writes
  input wire logic I_PRIMARY_WE,
  input wire logic I_SECONDARY_WE,
  input wire logic [15:0] I_DUTY_DATA,
  // Status
  output logic [15:0] O_TIMER_COUNT,
  output logic O_PERIOD_MATCH,
  // Pin
  output logic O_PWM_OUTPUT_PIN
);
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  // ==========================================================
  // Registers
  run_state_t state_reg;
  run_state_t state_next;
  logic osc_div_reg;
  logic [7:0] pre_cnt_reg;
  logic [15:0] timer_count_reg;
  logic [15:0] timer_period_reg;
  logic [15:0] duty_primary_reg;
  logic [15:0] duty_secondary_reg;
  logic [15:0] buf_primary_reg;
  logic [15:0] buf_secondary_reg;
  logic match_reg;
  logic [25:0] clk_count_reg;

  // ==========================================================
  // Decode
  logic [7:0] pre_last;
  always_comb begin
    case (I_PRESCALE)
      pwm_pkg::PRE_1: pre_last = pwm_pkg::PRE_1_LAST;
      pwm_pkg::PRE_8: pre_last = pwm_pkg::PRE_8_LAST;
      pwm_pkg::PRE_64: pre_last = pwm_pkg::PRE_64_LAST;
      pwm_pkg::PRE_256: pre_last = pwm_pkg::PRE_256_LAST;
      default: pre_last = pwm_pkg::PRE_1_LAST;
    endcase
  end

  wire running = state_reg == ST_RUN;
  // Instruction clock is every second edge
  wire cy_tick = running && (osc_div_reg == pwm_pkg::OSC_DIV_LAST);
  wire pre_done = pre_cnt_reg >= pre_last;
  wire tmr_tick = cy_tick && pre_done;
  // Full 16-bit compare; a period of FFFFh gives 16-bit resolution
  wire period_hit = timer_count_reg == timer_period_reg;
  wire roll = tmr_tick && period_hit;
  wire [15:0] count_inc = timer_count_reg + pwm_pkg::COUNT_ONE;
  wire [7:0] pre_inc = pre_cnt_reg + pwm_pkg::PRE_ONE;

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = I_ENABLE ? ST_RUN : ST_IDLE;
      ST_RUN: state_next = I_ENABLE ? ST_RUN : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Timer base
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_reg <= ST_IDLE;
      osc_div_reg <= 1'b0;
      pre_cnt_reg <= pwm_pkg::PRE_ZERO;
      timer_count_reg <= pwm_pkg::COUNT_ZERO;
    end else begin
      state_reg <= state_next;
      osc_div_reg <= running ? ~osc_div_reg : 1'b0;
      if (!running) begin
        pre_cnt_reg <= pwm_pkg::PRE_ZERO;
      end else if (cy_tick) begin
        pre_cnt_reg <= pre_done ? pwm_pkg::PRE_ZERO : pre_inc;
      end
      // Parked at zero when off, so a restart begins a full period
      if (!running || roll) begin
        timer_count_reg <= pwm_pkg::COUNT_ZERO;
      end else if (tmr_tick) begin
        timer_count_reg <= count_inc;
      end
    end
  end

  // ==========================================================
  // Double buffer
  // Period is latched with duties so both change on the same edge
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      buf_primary_reg <= pwm_pkg::COUNT_ZERO;
      buf_secondary_reg <= pwm_pkg::COUNT_ZERO;
      duty_primary_reg <= pwm_pkg::COUNT_ZERO;
      duty_secondary_reg <= pwm_pkg::COUNT_ZERO;
      timer_period_reg <= pwm_pkg::COUNT_ZERO;
      match_reg <= 1'b0;
    end else begin
      if (I_PRIMARY_WE) begin
        buf_primary_reg <= I_DUTY_DATA;
      end
      if (I_SECONDARY_WE) begin
        buf_secondary_reg <= I_DUTY_DATA;
      end
      // Idle channel applies at once, no period to protect
      if (roll || !running) begin
        duty_primary_reg <= buf_primary_reg;
        duty_secondary_reg <= buf_secondary_reg;
        timer_period_reg <= I_PERIOD;
      end
      match_reg <= roll;
    end
  end

  // ==========================================================
  // Output stage
  duty_if dbus ();
  assign dbus.primary = duty_primary_reg;
  assign dbus.secondary = duty_secondary_reg;
  assign dbus.period = timer_period_reg;
  assign dbus.count = timer_count_reg;
  assign dbus.tick = tmr_tick;
  assign dbus.period_match = roll;

  pwm_edge_stage u_edge (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .d(dbus),
    .o_pin(O_PWM_OUTPUT_PIN)
  );

  assign O_TIMER_COUNT = timer_count_reg;
  assign O_PERIOD_MATCH = match_reg;

  // ==========================================================
  // Checks
  // Clocks per period, counted apart from the timer itself
  wire [25:0] period_ticks = {10'h000, timer_period_reg} + 26'h0000001;
  wire [25:0] tick_clks = {17'h00000, pre_last, 1'b0} + 26'h0000002;
  wire [25:0] period_clks = period_ticks * tick_clks;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || roll || !running) begin
      clk_count_reg <= 26'h0000001;
    end else begin
      clk_count_reg <= clk_count_reg + 26'h0000001;
    end
  end

  shadow_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (running && !roll && $past(running)) |=>
    $stable(duty_secondary_reg))
    else $error("duty changed inside a period");
  shadow_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    roll |=> duty_primary_reg == $past(buf_primary_reg))
    else $error("duty not applied at period match");
  period_len_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    roll |-> clk_count_reg == period_clks)
    else $error("period length is not period plus one ticks");
  half_rate_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    cy_tick |=> !cy_tick)
    else $error("instruction tick on consecutive edges");
  count_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    roll |=> timer_count_reg == pwm_pkg::COUNT_ZERO)
    else $error("timer did not wrap at period match");
  count_bound_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    running |-> timer_count_reg <= timer_period_reg)
    else $error("timer ran past the period");
endmodule : pwm_channel

// ==== rtl/pwm_pkg.sv ====
// Package with widths, prescale codes and constants for the PWM channel
package pwm_pkg;
  // ==========================================================
  // Widths
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  // ==========================================================
  // Instruction clock divides the oscillator by two
  localparam logic OSC_DIV_LAST = 1'h1;
  // ==========================================================
  // Prescale ratio select codes
  localparam logic [1:0] PRE_1 = 2'h0;
  localparam logic [1:0] PRE_8 = 2'h1;
  localparam logic [1:0] PRE_64 = 2'h2;
  localparam logic [1:0] PRE_256 = 2'h3;
  localparam logic [7:0] PRE_1_LAST = 8'h00;
  localparam logic [7:0] PRE_8_LAST = 8'h07;
  localparam logic [7:0] PRE_64_LAST = 8'h3F;
  localparam logic [7:0] PRE_256_LAST = 8'hFF;
  localparam logic [7:0] PRE_ONE = 8'h01;
  localparam logic [7:0] PRE_ZERO = 8'h00;
endpackage : pwm_pkg

// ==== rtl/duty_if.sv ====
// Interface carrying the shadowed duty pair between timer and output stage
interface duty_if;
  logic [15:0] primary;
  logic [15:0] secondary;
  logic [15:0] period;
  logic [15:0] count;
  logic tick;
  logic period_match;
  modport src (output primary, secondary, period, count, tick,
    period_match);
  modport dst (input primary, secondary, period, count, tick,
    period_match);
endinterface : duty_if

// ==== rtl/pwm_edge_stage.sv ====
// Output stage that places the PWM edges from the shadowed duty pair
module pwm_edge_stage (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Timer and duty values
  duty_if.dst d,
  // Pin
  output logic o_pin
);
  // ==========================================================
  // Edge decode
  logic pin_reg;
  logic pin_next;
  wire all_zero = (d.primary == pwm_pkg::COUNT_ZERO) &&
    (d.secondary == pwm_pkg::COUNT_ZERO) &&
    (d.period == pwm_pkg::COUNT_ZERO);
  wire force_high = d.secondary > d.period;
  wire hit_rise = d.count == d.primary;
  wire hit_fall = d.count == d.secondary;

  // Fall wins when both edges coincide, giving a zero-width pulse
  always_comb begin
    pin_next = pin_reg;
    if (all_zero) begin
      pin_next = 1'b0;
    end else if (force_high) begin
      pin_next = 1'b1;
    end else if (d.tick && hit_fall) begin
      pin_next = 1'b0;
    end else if (d.tick && hit_rise) begin
      pin_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end
  assign o_pin = pin_reg;

  // ==========================================================
  // Checks
  zero_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    all_zero |=> !o_pin)
    else $error("pin not low with all values zero");
  over_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (force_high && !all_zero) |=> o_pin)
    else $error("pin not high with secondary above period");
  fall_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (d.tick && hit_fall && !force_high) |=> !o_pin)
    else $error("pin did not fall at secondary match");
  rise_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (d.tick && hit_rise && !hit_fall && !force_high && !all_zero)
    |=> o_pin)
    else $error("pin did not rise at primary match");
  hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!d.tick && !force_high && !all_zero) |=> $stable(o_pin))
    else $error("pin moved without a timer tick");
endmodule : pwm_edge_stage

// ==== testbench/duty_writer.sv ====
// Software-side model that writes the two duty buffers
module duty_writer (
  // Clock
  input wire logic i_clk,
  // Duty writes
  output logic o_primary_we,
  output logic o_secondary_we,
  output logic [15:0] o_duty_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_primary_we = 1'h0;
    o_secondary_we = 1'h0;
    o_duty_data = 16'h0000;
  end
  // One-cycle pulse, any cycle of the period
  task automatic write(input logic prim, input logic sec,
    input logic [15:0] val);
    @(negedge i_clk);
    o_primary_we = prim;
    o_secondary_we = sec;
    o_duty_data = val;
    @(negedge i_clk);
    o_primary_we = 1'h0;
    o_secondary_we = 1'h0;
    // Scrambled after release so no stale value is relied on
    o_duty_data = ~val;
  endtask : write
endmodule : duty_writer

// ==== testbench/double_buffered_pwm_output_tb.sv ====
// Self-checking bench for the double buffered PWM channel
module double_buffered_pwm_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic enable = 1'h0;
  logic [1:0] prescale = 2'h0;
  logic [15:0] period = 16'h0000;
  wire logic pwe;
  wire logic swe;
  wire logic [15:0] ddata;
  logic [15:0] tcount;
  logic pmatch;
  logic pin;
  int n_mismatch = 0;
  int n_checks = 0;
  // ==========================================================
  // Clock, design and writer
  always #4 clk = ~clk;
  pwm_channel pwm_channel_inst (.I_CLK(clk), .I_RST_N(rst_n),
    .I_ENABLE(enable), .I_PRESCALE(prescale), .I_PERIOD(period),
    .I_PRIMARY_WE(pwe), .I_SECONDARY_WE(swe), .I_DUTY_DATA(ddata),
    .O_TIMER_COUNT(tcount), .O_PERIOD_MATCH(pmatch),
    .O_PWM_OUTPUT_PIN(pin));
  duty_writer duty_writer_inst (.i_clk(clk), .o_primary_we(pwe),
    .o_secondary_we(swe), .o_duty_data(ddata));
  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk
  // Counts clocks and high cycles between two period matches
  task automatic measure(input bit sync, output int per, output int hi);
    int n;
    per = 0;
    hi = 0;
    n = 0;
    while (sync && pmatch !== 1'h1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    do begin
      @(negedge clk);
      per++;
      if (pin === 1'h1) hi++;
    end while (pmatch !== 1'h1 && per < 5000);
  endtask : measure
  // Disabled channel takes buffers at once, so start clean
  task automatic setup(input logic [1:0] pre, input logic [15:0] per,
    input logic [15:0] prim, input logic [15:0] sec);
    @(negedge clk);
    enable = 1'h0;
    prescale = pre;
    period = per;
    duty_writer_inst.write(1'h1, 1'h0, prim);
    duty_writer_inst.write(1'h0, 1'h1, sec);
    @(negedge clk);
    enable = 1'h1;
  endtask : setup
  // ==========================================================
  // Scenarios
  task automatic test_period;
    int p;
    int h;
    int ratio[4] = '{1, 8, 64, 256};
    for (int i = 0; i < 4; i++) begin
      setup(2'(i), 16'h0001, 16'h0000, 16'h0001);
      measure(1'b1, p, h);
      measure(1'b1, p, h);
      chk(p, 2 * 2 * ratio[i], "period length");
      chk(h, 2 * ratio[i], "high time");
    end
    $display("test_period done");
  endtask : test_period
  task automatic test_duty;
    int p;
    int h;
    setup(2'h0, 16'h0003, 16'h0000, 16'h0002);
    measure(1'b1, p, h);
    measure(1'b1, p, h);
    chk(h, 4, "rise at primary fall at secondary");
    chk(p, 8, "instruction rate period");
    chk(tcount, 16'h0000, "count wraps to zero");
    repeat (2) @(negedge clk);
    chk(tcount, 16'h0001, "count steps at instruction rate");
    setup(2'h0, 16'h0003, 16'h0001, 16'h0003);
    measure(1'b1, p, h);
    measure(1'b1, p, h);
    chk(h, 4, "secondary equal to period");
    setup(2'h0, 16'h0000, 16'h0000, 16'h0000);
    measure(1'b1, p, h);
    measure(1'b1, p, h);
    chk(h, 0, "all zero stays low");
    setup(2'h0, 16'h0003, 16'h0001, 16'h0005);
    measure(1'b1, p, h);
    measure(1'b1, p, h);
    chk(h, 8, "secondary above period stays high");
    $display("test_duty done");
  endtask : test_duty
  task automatic test_buffer;
    int p;
    int h;
    setup(2'h1, 16'h0003, 16'h0000, 16'h0002);
    measure(1'b1, p, h);
    measure(1'b1, p, h);
    // Mid-period write must wait for the wrap
    duty_writer_inst.write(1'h0, 1'h1, 16'h0001);
    measure(1'b0, p, h);
    chk(h, 32, "old duty kept to period end");
    measure(1'b0, p, h);
    chk(h, 16, "new duty after match");
    $display("test_buffer done");
  endtask : test_buffer
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(negedge clk);
    chk(int'(tcount === 16'h0000 && pin === 1'h0), 1, "reset outputs");
    rst_n = 1'h1;
    test_period;
    test_duty;
    test_buffer;
    tally_and_finish;
  end
  // Run needs about 4400 cycles; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule : double_buffered_pwm_output_tb
